// ==== hdl/slpc_defs.svh ====
// offsets, field positions, reset values and timing counts for the status led and preset block
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH

// register byte offsets
`define SLPC_OFS_SEL      8'h00
`define SLPC_OFS_ROT      8'h04
`define SLPC_OFS_PARAM    8'h08
`define SLPC_OFS_ACTIVE   8'h0c
`define SLPC_OFS_LEDREQ   8'h10
`define SLPC_OFS_LEDSTAT  8'h14
`define SLPC_OFS_MEAS     8'h18

// preset identifiers and the user preset default word
`define SLPC_USER_LAST    7'h0f
`define SLPC_FACT_FIRST   7'h40
`define SLPC_FACT_LAST    7'h4e
`define SLPC_RESET_PRESET 7'h00
`define SLPC_USER_DEFAULT 32'h0000_1408

// parameter word fields: [7:0] peaks, [15:8] bins, [19:16] windows, [23:20] bw code, [31:24] interval code
`define SLPC_FACT_ULP     32'h1840_0104
`define SLPC_FACT_LEGACY  32'h1000_1408

// timing, in milliseconds and in cycles of the 25 mhz clock
`define SLPC_CLK_HZ       25000000
`define SLPC_MS_CYC       ((`SLPC_CLK_HZ) / 1000)
`define SLPC_POWERON_MS   2000
`define SLPC_ERROR_MS     1000
`define SLPC_FLASH_MS     5
`define SLPC_GAP_MS       100

`endif

// ==== hdl/slpc_pkg.sv ====
// types for the status led and preset block
package slpc_pkg;
   typedef enum logic [2:0] {
      LED_REQ_NONE,
      LED_REQ_JOIN,
      LED_REQ_UPLINK,
      LED_REQ_SUCCESS,
      LED_REQ_FAIL,
      LED_REQ_TAP
   } slpc_led_req_t;
   typedef logic [6:0] slpc_id_t;
   typedef logic [31:0] slpc_word_t;
endpackage

// ==== hdl/slpc_top.sv ====
// status led sequencer and preset manager with an ahb-lite register slave
//
// Overview of operation
// R1 - two second steady led after reset
// R2 - join request gives three very short flashes
// R3 - uplink transmission gives one very short flash
// R4 - join accept gives one more short flash
// R5 - failure lights led steadily one second
// R6 - duty-cycle refused join: error after triple flash
// R7 - no join answer: one second led
// R8 - uplink acknowledge gives second brief flash
// R9 - duty-cycle refused uplink: error after flash
// R10 - missing confirmed ack: one second led
// R11 - user preset zero active after reset
// R12 - setting changes go only to preset zero
// R13 - sixteen user presets, fifteen factory presets
// R14 - factory presets are never modified
// R15 - preset selected by writing selection register anytime
// R16 - loaded preset parameters apply at once
// R17 - radio edits only when active preset user
// R18 - rotating mode alternates two presets forever
// R19 - servicer resets battery estimator after replacement (this block has no battery estimator)
// R20 - finish current pattern, queue one request
// R21 - flash and gap lengths are constants
// R22 - magnet tap gives one short flash, triggers
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "slpc_defs.svh"

module slpc_top
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                meas_done,
   input  wire logic                radio_edit,
   input  wire slpc_pkg::slpc_word_t radio_param,
   input  wire logic                magnet_tap,
   output logic                     led_on,
   output slpc_pkg::slpc_word_t     active_param,
   output slpc_pkg::slpc_id_t       active_id,
   output logic                     meas_trigger,
   output logic                     tx_trigger
);
   import slpc_pkg::*;

   localparam int POWERON_CYC = `SLPC_POWERON_MS * `SLPC_MS_CYC;
   localparam int ERROR_CYC   = `SLPC_ERROR_MS * `SLPC_MS_CYC;
   localparam int FLASH_CYC   = `SLPC_FLASH_MS * `SLPC_MS_CYC;
   localparam int GAP_CYC     = `SLPC_GAP_MS * `SLPC_MS_CYC;

   // ---------------------------------------------------------------
   // preset decode helpers
   // ---------------------------------------------------------------
   function automatic logic is_user(input slpc_id_t id);
      is_user = (id <= `SLPC_USER_LAST);
   endfunction

   function automatic logic is_valid(input slpc_id_t id);
      is_valid = is_user(id) || ((id >= `SLPC_FACT_FIRST) && (id <= `SLPC_FACT_LAST));
   endfunction

   // factory parameters are constants, so they can never change
   function automatic slpc_word_t factory_word(input slpc_id_t id);
      logic [3:0] k;
      k = id[3:0];
      if (k == 4'h0)
         factory_word = `SLPC_FACT_LEGACY;
      else
         factory_word = `SLPC_FACT_ULP | {4'h0, k, 24'h00_0000};  // [R14]
   endfunction

   // ---------------------------------------------------------------
   // ahb-lite slave
   // ---------------------------------------------------------------
   logic        wr_pend_q;
   logic [7:0]  addr_q;
   logic        rd_pend_q;
   logic        acc;

   assign acc = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_q <= acc && hwrite;
         rd_pend_q <= acc && !hwrite;
         addr_q    <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   logic wr_sel;
   logic wr_rot;
   logic wr_param;
   logic wr_led;
   logic wr_meas;

   assign wr_sel   = wr_pend_q && (addr_q == `SLPC_OFS_SEL);
   assign wr_rot   = wr_pend_q && (addr_q == `SLPC_OFS_ROT);
   assign wr_param = wr_pend_q && (addr_q == `SLPC_OFS_PARAM);
   assign wr_led   = wr_pend_q && (addr_q == `SLPC_OFS_LEDREQ);
   assign wr_meas  = wr_pend_q && (addr_q == `SLPC_OFS_MEAS);

   // ---------------------------------------------------------------
   // preset storage and selection
   // ---------------------------------------------------------------
   slpc_word_t user_mem [16];  // [R13]
   slpc_id_t   rot_a_q;
   slpc_id_t   rot_b_q;
   logic       rot_en_q;
   logic       rot_phase_q;
   slpc_id_t   load_id;
   logic       load_req;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rot_en_q <= 1'b0;
         rot_a_q  <= `SLPC_RESET_PRESET;
         rot_b_q  <= `SLPC_RESET_PRESET;
      end
      else if (wr_rot)
      begin
         rot_en_q <= hwdata[31];
         rot_a_q  <= hwdata[6:0];
         rot_b_q  <= hwdata[14:8];
      end
   end

   // rotating mode swaps presets after each measurement
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rot_phase_q <= 1'b0;
      else if (wr_rot)
         rot_phase_q <= 1'b0;
      else if (rot_en_q && meas_done)
         rot_phase_q <= !rot_phase_q;  // [R18]
   end

   always_comb
   begin
      load_req = 1'b0;
      load_id  = active_id;
      if (wr_sel && is_valid(hwdata[6:0]))
      begin
         load_req = 1'b1;  // [R15]
         load_id  = hwdata[6:0];
      end
      else if (rot_en_q && meas_done)
      begin
         load_req = 1'b1;  // [R18]
         load_id  = rot_phase_q ? rot_a_q : rot_b_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         active_id <= `SLPC_RESET_PRESET;  // [R11]
      else if (load_req)
         active_id <= load_id;
   end

   logic       edit_en;
   slpc_word_t edit_word;

   always_comb
   begin
      edit_en   = 1'b0;
      edit_word = hwdata;
      if (wr_param)
      begin
         edit_en = 1'b1;  // [R12]
      end
      else if (radio_edit && is_user(active_id))
      begin
         edit_en   = 1'b1;  // [R17]
         edit_word = radio_param;
      end
   end

   // settings always land in preset zero; radio edits need a user preset active
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_user
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               user_mem[gi] <= `SLPC_USER_DEFAULT;
            else if (edit_en && (gi == 0))
               user_mem[gi] <= edit_word;  // [R12]
         end
      end
   endgenerate

   // parameters follow the loaded preset in the very next cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         active_param <= `SLPC_USER_DEFAULT;
      else if (load_req)
         active_param <= is_user(load_id) ? user_mem[load_id[3:0]] : factory_word(load_id);  // [R16]
      else if (edit_en && (active_id == 7'h00))
         active_param <= edit_word;  // [R16]
   end

   // ---------------------------------------------------------------
   // magnet tap and measurement triggers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meas_trigger <= 1'b0;
         tx_trigger   <= 1'b0;
      end
      else
      begin
         meas_trigger <= magnet_tap || (wr_meas && hwdata[0]);  // [R22]
         tx_trigger   <= magnet_tap || (wr_meas && hwdata[0]);  // [R22]
      end
   end

   // ---------------------------------------------------------------
   // led sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ON,
      ST_GAP
   } slpc_led_st_t;

   slpc_led_st_t  st_q;
   logic [31:0]   cnt_q;
   logic [1:0]    flashes_q;
   slpc_led_req_t pend_q;
   logic          pend_v_q;
   slpc_led_req_t new_req;

   always_comb
   begin
      new_req = LED_REQ_NONE;
      if (magnet_tap)
         new_req = LED_REQ_TAP;  // [R22]
      else if (wr_led)
         new_req = slpc_led_req_t'(hwdata[2:0]);
   end

   logic start;
   assign start = (st_q == ST_IDLE) && pend_v_q;

   // one pending slot; newer request overwrites it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_v_q <= 1'b0;
         pend_q   <= LED_REQ_NONE;
      end
      else if (new_req != LED_REQ_NONE)
      begin
         pend_v_q <= 1'b1;  // [R20]
         pend_q   <= new_req;
      end
      else if (start)
         pend_v_q <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q      <= ST_ON;
         cnt_q     <= 32'(POWERON_CYC - 1);  // [R1]
         flashes_q <= 2'd0;
         led_on    <= 1'b1;  // [R1]
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               led_on <= 1'b0;
               if (pend_v_q)
               begin
                  st_q   <= ST_ON;
                  led_on <= 1'b1;
                  case (pend_q)
                     LED_REQ_JOIN:
                     begin
                        cnt_q     <= 32'(FLASH_CYC - 1);  // [R2] [R21]
                        flashes_q <= 2'd2;
                     end
                     LED_REQ_FAIL:
                     begin
                        cnt_q     <= 32'(ERROR_CYC - 1);  // [R5] [R6] [R7] [R9] [R10]
                        flashes_q <= 2'd0;
                     end
                     default:
                     begin
                        cnt_q     <= 32'(FLASH_CYC - 1);  // [R3] [R4] [R8] [R21]
                        flashes_q <= 2'd0;
                     end
                  endcase
               end
            end
            ST_ON:
            begin
               if (cnt_q == 32'd0)
               begin
                  led_on <= 1'b0;
                  if (flashes_q != 2'd0)
                  begin
                     st_q  <= ST_GAP;
                     cnt_q <= 32'(GAP_CYC - 1);  // [R21]
                  end
                  else
                     st_q <= ST_IDLE;  // [R20]
               end
               else
                  cnt_q <= cnt_q - 32'd1;
            end
            ST_GAP:
            begin
               if (cnt_q == 32'd0)
               begin
                  st_q      <= ST_ON;
                  led_on    <= 1'b1;
                  cnt_q     <= 32'(FLASH_CYC - 1);  // [R2]
                  flashes_q <= flashes_q - 2'd1;
               end
               else
                  cnt_q <= cnt_q - 32'd1;
            end
            default:
            begin
               st_q   <= ST_IDLE;
               led_on <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (acc && !hwrite)
      begin
         case (haddr[7:0])
            `SLPC_OFS_SEL:     hrdata <= {25'h000_0000, active_id};
            `SLPC_OFS_ROT:     hrdata <= {rot_en_q, 14'h0000, rot_phase_q, 1'b0, rot_b_q, 1'b0, rot_a_q};
            `SLPC_OFS_PARAM:   hrdata <= user_mem[0];
            `SLPC_OFS_ACTIVE:  hrdata <= active_param;
            `SLPC_OFS_LEDSTAT: hrdata <= {27'h000_0000, pend_v_q, led_on, st_q};
            default:           hrdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// ==== verification/slpc_chk.sv ====
// assertion checker for the status led and preset block
`timescale 1ns/100ps
`include "slpc_defs.svh"
module slpc_chk
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 radio_edit,
   input wire slpc_pkg::slpc_word_t radio_param,
   input wire logic                 magnet_tap,
   input wire logic                 led_on,
   input wire slpc_pkg::slpc_word_t active_param,
   input wire slpc_pkg::slpc_id_t   active_id,
   input wire logic                 meas_trigger,
   input wire logic                 tx_trigger
);
   import slpc_pkg::*;
   logic       sel_q;
   slpc_word_t edit_q;
   logic       valid_id;
   assign valid_id = hwdata[6:0] <= `SLPC_USER_LAST ||
                     (hwdata[6:0] >= `SLPC_FACT_FIRST && hwdata[6:0] <= `SLPC_FACT_LAST);
   // selection write in its data phase
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         sel_q <= 1'b0;
      else if (hready)
         sel_q <= hsel && htrans[1] && hwrite && haddr[7:0] == `SLPC_OFS_SEL;
   always_ff @(posedge hclk)
      if (radio_edit)
         edit_q <= radio_param;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   zero_wait_a : assert property (hreadyout && !hresp)
      else $error("slave stalled or answered an error");
   reset_state_a : assert property ($rose(hresetn) |->
      (led_on && active_id == `SLPC_RESET_PRESET && active_param == `SLPC_USER_DEFAULT))
      else $error("wrong state after reset");
   poweron_led_a : assert property ($rose(hresetn) |-> led_on [*8])
      else $error("led not held on after reset");
   sel_load_a : assert property (sel_q && valid_id |=> active_id == $past(hwdata[6:0]))
      else $error("valid preset id not loaded");
   sel_refuse_a : assert property (sel_q && !valid_id |=> $stable(active_id))
      else $error("invalid preset id accepted");
   factory_param_a : assert property (active_id == `SLPC_FACT_FIRST && $stable(active_id) |->
      active_param == `SLPC_FACT_LEGACY)
      else $error("factory preset parameters wrong");
   user_edit_a : assert property (radio_edit && active_id <= `SLPC_USER_LAST |->
      ##[1:2] active_param == edit_q)
      else $error("radio edit not applied to user preset");
   factory_edit_a : assert property (radio_edit && active_id > `SLPC_USER_LAST |=> $stable(active_param))
      else $error("factory preset modified");
   meas_pulse_a : assert property (meas_trigger |=> !meas_trigger)
      else $error("measurement trigger longer than a cycle");
   tap_meas_a : assert property ($rose(magnet_tap) |-> ##[1:4] meas_trigger)
      else $error("tap did not trigger a measurement");
   tap_tx_a : assert property ($rose(magnet_tap) |-> ##[1:4] tx_trigger)
      else $error("tap did not trigger a transmission");
endmodule

// ==== verification/slpc_radio_model.sv ====
// measurement and radio sequencer model facing the preset block
`timescale 1ns/100ps
module slpc_radio_model
#(
   parameter int MEAS_CYC = 20
)
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 meas_trigger,
   input  wire logic                 edit_go,
   input  wire slpc_pkg::slpc_word_t edit_val,
   output logic                      meas_done,
   output logic                      radio_edit,
   output slpc_pkg::slpc_word_t      radio_param
);
   import slpc_pkg::*;
   int cnt_q;
   // measurement ends a fixed time after its trigger
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         cnt_q     <= 0;
         meas_done <= 1'b0;
      end
      else
      begin
         meas_done <= cnt_q == 1;
         cnt_q     <= meas_trigger ? MEAS_CYC : (cnt_q > 0 ? cnt_q - 1 : 0);
      end
   // parameter word is only meaningful with its strobe
   always_ff @(posedge clk)
   begin
      radio_edit  <= edit_go;
      radio_param <= edit_go ? edit_val : ~radio_param;
   end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the status led and preset block
`timescale 1ns/100ps
`include "slpc_defs.svh"
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); \
      end \
   end
module tb_top;
   import slpc_pkg::*;
   logic       hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic       meas_done, radio_edit, magnet_tap, edit_go, led_on, meas_trigger;
   logic [1:0] htrans;
   logic [2:0] hsize;
   slpc_word_t haddr, hwdata, hrdata, active_param, edit_val, radio_param, rd;
   slpc_id_t   active_id;
   int         fails, comparisons;
   slpc_id_t   ids[7] = '{7'h10, 7'h3f, 7'h4f, 7'h7f, 7'h4e, 7'h0f, 7'h00};
   slpc_id_t   exp_ids[7] = '{7'h40, 7'h40, 7'h40, 7'h40, 7'h4e, 7'h0f, 7'h00};
   assign hready = hreadyout;
   slpc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .meas_done, .radio_edit, .radio_param, .magnet_tap, .led_on,
      .active_param, .active_id, .meas_trigger, .tx_trigger());
   slpc_radio_model #(.MEAS_CYC(20)) model (.clk(hclk), .rst_n(hresetn), .meas_trigger, .edit_go,
      .edit_val, .meas_done, .radio_edit, .radio_param);
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic summarize();
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
         if (n > 50)
         begin
            fails++;
            summarize();
         end
      end
      while (hready !== 1'b1);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input slpc_word_t wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input slpc_word_t e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic edit(input slpc_word_t v);
      edit_val <= v;
      edit_go  <= 1'b1;
      @(posedge hclk);
      edit_go  <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic wait_id(input slpc_id_t v);
      int n;
      n = 0;
      while (active_id !== v && n < 200)
      begin
         @(posedge hclk);
         n++;
      end
      `CHK(active_id, v)
      if (n >= 200)
         summarize();
   endtask
   initial
   begin
      repeat (20000) @(posedge hclk);
      fails++;
      summarize();
   end
   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; magnet_tap = 1'b0; edit_go = 1'b0; edit_val = 32'h0; fails = 0; comparisons = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK(led_on, 1'b1)
      rdchk(`SLPC_OFS_ACTIVE, `SLPC_USER_DEFAULT);
      for (int c = 1; c <= 4; c++)
      begin
         xfer(1'b1, `SLPC_OFS_LEDREQ, c);
         xfer(1'b0, `SLPC_OFS_LEDSTAT, 32'h0);
         `CHK(rd[4:3], 2'b11)
      end
      xfer(1'b1, `SLPC_OFS_PARAM, 32'h2130_1006);
      rdchk(`SLPC_OFS_ACTIVE, 32'h2130_1006);
      edit(32'h1850_0203);
      `CHK(active_param, 32'h1850_0203)
      xfer(1'b1, `SLPC_OFS_SEL, 32'h40);
      rdchk(`SLPC_OFS_SEL, 32'h40);
      rdchk(`SLPC_OFS_ACTIVE, `SLPC_FACT_LEGACY);
      edit(32'hffff_ffff);
      `CHK(active_param, `SLPC_FACT_LEGACY)
      xfer(1'b1, `SLPC_OFS_PARAM, 32'h0000_0001);
      `CHK(active_param, `SLPC_FACT_LEGACY)
      rdchk(`SLPC_OFS_PARAM, 32'h0000_0001);
      xfer(1'b1, 8'h1c, 32'hffff_ffff);
      rdchk(8'h1c, 32'h0);
      foreach (ids[i])
      begin
         xfer(1'b1, `SLPC_OFS_SEL, {25'h0, ids[i]});
         rdchk(`SLPC_OFS_SEL, {25'h0, exp_ids[i]});
      end
      // rotation between preset 0 and the first factory preset
      xfer(1'b1, `SLPC_OFS_ROT, 32'h8000_4000);
      for (int k = 0; k < 3; k++)
      begin
         xfer(1'b1, `SLPC_OFS_MEAS, 32'h1);
         wait_id(k[0] ? 7'h00 : 7'h40);
      end
      xfer(1'b1, `SLPC_OFS_ROT, 32'h0);
      magnet_tap <= 1'b1;
      @(posedge hclk);
      magnet_tap <= 1'b0;
      repeat (30) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(`SLPC_OFS_SEL, 32'h0);
      rdchk(`SLPC_OFS_ACTIVE, `SLPC_USER_DEFAULT);
      summarize();
   end
endmodule
bind slpc_top slpc_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hreadyout, .hresp, .radio_edit, .radio_param, .magnet_tap, .led_on, .active_param, .active_id,
   .meas_trigger, .tx_trigger);
